// [common/ccs_pkg.sv]
// Package for the clock select and short chip select block
package ccs_pkg;
	localparam logic [1:0] ADDR_GCS  = 2'h0;
	localparam logic [1:0] ADDR_PSC  = 2'h1;
	localparam logic [1:0] ADDR_IST  = 2'h2;
	localparam logic [1:0] ADDR_IMSK = 2'h3;
	localparam int GCS_RST_HI  = 7;
	localparam int GCS_RST_LO  = 6;
	localparam int GCS_FORCE   = 5;
	localparam int GCS_SEL_HI  = 4;
	localparam int GCS_SEL_LO  = 2;
	localparam int GCS_PRIO_HI = 1;
	localparam int GCS_PRIO_LO = 0;
	localparam int PSC_TW_HI   = 7;
	localparam int PSC_TW_LO   = 5;
	localparam int PSC_SHRD    = 4;
	localparam int PSC_SHWR    = 3;
	localparam int PSC_FR_HI   = 2;
	localparam int PSC_FR_LO   = 0;
	localparam int IST_WDT     = 0;
	localparam int IST_SWITCH  = 1;
	localparam logic [1:0] RST_NONE  = 2'h0;
	localparam logic [1:0] RST_WDT   = 2'h1;
	localparam logic [1:0] RST_RESET = 2'h3;
	localparam logic [2:0] SEL_D8    = 3'h0;
	localparam logic [2:0] SEL_D8P1  = 3'h1;
	localparam logic [2:0] SEL_FULL  = 3'h2;
	localparam logic [2:0] SEL_D2    = 3'h3;
	localparam logic [2:0] SEL_SLOW  = 3'h4;
	localparam logic [2:0] SEL_SLOFF = 3'h5;
	localparam logic [2:0] SEL_D4    = 3'h6;
	localparam logic [2:0] SEL_D6    = 3'h7;
	localparam logic [2:0] SEL_RESET = 3'h0;
	localparam logic [7:0] PSC_RESET = 8'h00;
	localparam logic [1:0] PRIO_RESET = 2'h0;
	localparam int CLK_NS      = 20;
	localparam int TW_NS_100   = 296;
	localparam int TW_NS_101   = 234;
	localparam int TW_NS_110   = 171;
	localparam int TW_NS_111   = 109;
	localparam logic [4:0] TW_CYC_100 = 5'(TW_NS_100 / CLK_NS);
	localparam logic [4:0] TW_CYC_101 = 5'(TW_NS_101 / CLK_NS);
	localparam logic [4:0] TW_CYC_110 = 5'(TW_NS_110 / CLK_NS);
	localparam logic [4:0] TW_CYC_111 = 5'(TW_NS_111 / CLK_NS);
	localparam logic [1:0] FAST_CS_CYC = 2'h2;
	typedef struct packed {
		logic cs;
		logic rd;
		logic wr;
		logic final_st;
	} ccs_bus_s;
endpackage

// [rtl/ccs_top.sv]
// Clock select, status, periodic interrupt and short chip select logic
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Reset status 00/01/11, cleared by read
// - Force bit sets periodic pending, reads zero
// - Periodic field: off or priority 1-3
// - Clock select divides processor and peripheral clocks
// - Codes 100/101 run from slow clock
// - Full speed has no chip select shaping
// - Short read select covers final part only
// - Fast short read select two cycles
// - Short options also at slow rates
// - Slow short read select one slow cycle
// - Short write select around strobe trailing edge
// - Fast write select two before, two after
// - Slow write select one before, one after
// - Separate read and write short enables
// - Slow fraction divides by 2,4,8,16
// - Self-timed width field selects nominal widths
module ccs_top (
	input  wire logic            i_mclk,
	input  wire logic            i_rst_n,
	input  wire logic            i_ce,
	input  wire logic [1:0]      i_addr,
	input  wire logic [7:0]      i_wdata,
	input  wire logic            i_wr,
	input  wire logic            i_rd,
	output logic      [7:0]      o_rdata,
	input  wire logic            i_slow_clk,
	input  wire logic            i_wdt_timeout,
	input  wire logic            i_periodic_tick,
	input  wire logic            i_periodic_ack,
	input  wire ccs_pkg::ccs_bus_s i_bus,
	output logic                 o_cpu_tick,
	output logic                 o_per_tick,
	output logic                 o_osc_run,
	output logic                 o_periodic_pend,
	output logic      [1:0]      o_periodic_prio,
	output logic                 o_mem_cs,
	output logic                 o_irq
);
	logic [1:0] rst_stat_ff;
	logic [2:0] csel_ff;
	logic [2:0] sel_ff;
	logic [1:0] prio_ff;
	logic [7:0] psc_ff;
	logic [1:0] ist_ff;
	logic [1:0] imsk_ff;
	logic       pend_ff;
	logic [7:0] rdata_ff;
	logic [2:0] cnt_ff;
	logic [3:0] scnt_ff;
	logic       slow_q_ff;
	logic [1:0] post_ff;
	logic       spost_ff;
	logic [4:0] tcnt_ff;
	logic       final_q_ff;
	logic       cs_ff;
	logic [3:0] div;
	logic [4:0] sdiv;
	logic [4:0] tw_cyc;
	logic       wr_gcs;
	logic       rd_gcs;
	logic       slow_edge;
	logic       slow_mode;
	logic       fast_end;
	logic       slow_end;
	logic       per_end;
	logic       fast_last2;
	logic       slow_last;
	logic       sh_rd;
	logic       sh_wr;
	logic       timed;
	logic       nxt_cs;

	assign wr_gcs = i_wr && (i_addr == ccs_pkg::ADDR_GCS);
	assign rd_gcs = i_rd && (i_addr == ccs_pkg::ADDR_GCS);
	assign slow_edge = i_slow_clk && !slow_q_ff;
	assign slow_mode = (sel_ff == ccs_pkg::SEL_SLOW) ||
		(sel_ff == ccs_pkg::SEL_SLOFF);

	// Main oscillator divide ratio
	always_comb begin
		unique case (sel_ff)
			ccs_pkg::SEL_FULL: div = 4'h1;
			ccs_pkg::SEL_D2:   div = 4'h2;
			ccs_pkg::SEL_D4:   div = 4'h4;
			ccs_pkg::SEL_D6:   div = 4'h6;
			default:           div = 4'h8;
		endcase
	end

	// Slow clock fraction
	always_comb begin
		unique case (psc_ff[ccs_pkg::PSC_FR_HI:ccs_pkg::PSC_FR_LO])
			3'h4:    sdiv = 5'h02;
			3'h5:    sdiv = 5'h04;
			3'h6:    sdiv = 5'h08;
			3'h7:    sdiv = 5'h10;
			default: sdiv = 5'h01;
		endcase
	end

	// Self-timed width in clock cycles
	always_comb begin
		unique case (psc_ff[ccs_pkg::PSC_TW_HI:ccs_pkg::PSC_TW_LO])
			3'h4:    tw_cyc = ccs_pkg::TW_CYC_100;
			3'h5:    tw_cyc = ccs_pkg::TW_CYC_101;
			3'h6:    tw_cyc = ccs_pkg::TW_CYC_110;
			3'h7:    tw_cyc = ccs_pkg::TW_CYC_111;
			default: tw_cyc = 5'h00;
		endcase
	end

	assign fast_end = ({1'b0, cnt_ff} == div - 4'h1);
	assign slow_last = ({1'b0, scnt_ff} >= sdiv - 5'h01);
	assign slow_end = slow_edge && slow_last;
	assign per_end = slow_mode ? slow_end : fast_end;
	assign fast_last2 = ({1'b0, cnt_ff} >= div - 4'h2);
	assign o_cpu_tick = i_ce && per_end;
	assign o_per_tick = i_ce && ((sel_ff == ccs_pkg::SEL_D8P1) ||
		per_end);
	assign o_osc_run = (sel_ff != ccs_pkg::SEL_SLOFF);

	// Short modes: none at full speed
	assign sh_rd = psc_ff[ccs_pkg::PSC_SHRD] &&
		(sel_ff != ccs_pkg::SEL_FULL);
	assign sh_wr = psc_ff[ccs_pkg::PSC_SHWR] &&
		(sel_ff != ccs_pkg::SEL_FULL);
	assign timed = slow_mode && (tw_cyc != 5'h00);

	// Divider counters
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cnt_ff <= 3'h0;
			scnt_ff <= 4'h0;
			slow_q_ff <= i_slow_clk;
		end else if (i_ce) begin
			slow_q_ff <= i_slow_clk;
			// Restart on every boundary, also leaving slow modes
			cnt_ff <= (fast_end || per_end) ? 3'h0 : cnt_ff + 3'h1;
			if (slow_edge)
				scnt_ff <= slow_last ? 4'h0 : scnt_ff + 4'h1;
		end
	end

	// Selection applied only at a period boundary
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			sel_ff <= ccs_pkg::SEL_RESET;
		else if (i_ce && per_end)
			sel_ff <= csel_ff;
	end

	// Software registers
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			csel_ff <= ccs_pkg::SEL_RESET;
			prio_ff <= ccs_pkg::PRIO_RESET;
			psc_ff <= ccs_pkg::PSC_RESET;
			imsk_ff <= 2'h0;
		end else if (i_ce && i_wr) begin
			unique case (i_addr)
				ccs_pkg::ADDR_GCS: begin
					csel_ff <= i_wdata[ccs_pkg::GCS_SEL_HI:ccs_pkg::GCS_SEL_LO];
					prio_ff <= i_wdata[ccs_pkg::GCS_PRIO_HI:ccs_pkg::GCS_PRIO_LO];
				end
				ccs_pkg::ADDR_PSC:  psc_ff <= i_wdata;
				ccs_pkg::ADDR_IMSK: imsk_ff <= i_wdata[1:0];
				default: ;
			endcase
		end
	end

	// Reset status, cleared by a read; a timeout wins
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			rst_stat_ff <= ccs_pkg::RST_RESET;
		else if (i_ce) begin
			if (i_wdt_timeout)
				rst_stat_ff <= ccs_pkg::RST_WDT;
			else if (rd_gcs)
				rst_stat_ff <= ccs_pkg::RST_NONE;
		end
	end

	// Periodic interrupt pending
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			pend_ff <= 1'b0;
		else if (i_ce) begin
			if (i_periodic_tick || (wr_gcs && i_wdata[ccs_pkg::GCS_FORCE]))
				pend_ff <= 1'b1;
			else if (i_periodic_ack)
				pend_ff <= 1'b0;
		end
	end
	assign o_periodic_pend = pend_ff && (prio_ff != 2'h0);
	assign o_periodic_prio = prio_ff;

	// Interrupt status, write one to clear, set wins
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			ist_ff <= 2'h0;
		else if (i_ce) begin
			if (i_wr && (i_addr == ccs_pkg::ADDR_IST))
				ist_ff <= (ist_ff & ~i_wdata[1:0]) |
					{per_end && (sel_ff != csel_ff), i_wdt_timeout};
			else
				ist_ff <= ist_ff |
					{per_end && (sel_ff != csel_ff), i_wdt_timeout};
		end
	end
	assign o_irq = |(ist_ff & imsk_ff);

	// Read data, one cycle after the strobe
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			rdata_ff <= 8'h00;
		else if (i_ce) begin
			if (!i_rd)
				rdata_ff <= 8'h00;
			else begin
				unique case (i_addr)
					ccs_pkg::ADDR_GCS:
						rdata_ff <= {rst_stat_ff, 1'b0, csel_ff, prio_ff};
					ccs_pkg::ADDR_PSC:  rdata_ff <= psc_ff;
					ccs_pkg::ADDR_IST:  rdata_ff <= {6'h00, ist_ff};
					default:            rdata_ff <= {6'h00, imsk_ff};
				endcase
			end
		end
	end
	assign o_rdata = rdata_ff;

	// Trailing select after the write strobe edge and self-timed width
	always_ff @(posedge i_mclk) begin
		if (!i_rst_n) begin
			post_ff <= 2'h0;
			spost_ff <= 1'b0;
			tcnt_ff <= 5'h00;
			final_q_ff <= 1'b0;
		end else if (i_ce) begin
			final_q_ff <= i_bus.final_st;
			if (!slow_mode && sh_wr && i_bus.wr && i_bus.final_st && fast_end)
				post_ff <= ccs_pkg::FAST_CS_CYC;
			else if (post_ff != 2'h0)
				post_ff <= post_ff - 2'h1;
			if (slow_mode && sh_wr && i_bus.wr && i_bus.final_st && slow_end)
				spost_ff <= 1'b1;
			else if (slow_edge)
				spost_ff <= 1'b0;
			if (timed && i_bus.final_st && !final_q_ff)
				tcnt_ff <= tw_cyc;
			else if (tcnt_ff != 5'h00)
				tcnt_ff <= tcnt_ff - 5'h01;
		end
	end

	// Chip select shaping
	always_comb begin
		nxt_cs = i_bus.cs;
		if ((i_bus.rd && sh_rd) || (i_bus.wr && sh_wr))
			nxt_cs = i_bus.final_st &&
				(slow_mode ? slow_last : fast_last2);
		else if (timed && (i_bus.rd || i_bus.wr))
			nxt_cs = (i_bus.final_st && !final_q_ff) ||
				(tcnt_ff > 5'h01);
		if ((post_ff != 2'h0) || spost_ff)
			nxt_cs = 1'b1;
	end

	always_ff @(posedge i_mclk) begin
		if (!i_rst_n)
			cs_ff <= 1'b0;
		else if (i_ce)
			cs_ff <= nxt_cs;
	end
	assign o_mem_cs = cs_ff;

	logic fast_rd_mode;
	logic fast_wr_mode;
	assign fast_rd_mode = sh_rd && !slow_mode && i_bus.rd && !i_bus.wr;
	assign fast_wr_mode = sh_wr && !slow_mode && i_bus.wr && !i_bus.rd;

	rst_clear_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && rd_gcs && !i_wdt_timeout) |=> rst_stat_ff == 2'h0)
		else $error("reset status not cleared by read");
	rst_never_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		rst_stat_ff != 2'h2)
		else $error("reset status shows 10");
	force_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$past(i_ce && rd_gcs) |-> !o_rdata[ccs_pkg::GCS_FORCE])
		else $error("force bit read back as one");
	force_pend_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && wr_gcs && i_wdata[ccs_pkg::GCS_FORCE]) |=> pend_ff)
		else $error("force write did not set pending");
	prio_off_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(prio_ff == 2'h0) |-> !o_periodic_pend)
		else $error("periodic pending while disabled");
	full_tick_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		(i_ce && sel_ff == ccs_pkg::SEL_FULL) |-> o_cpu_tick && o_per_tick)
		else $error("full speed tick missing");
	osc_off_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		o_osc_run == (sel_ff != ccs_pkg::SEL_SLOFF))
		else $error("oscillator run wrong");
	full_plain_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n || !i_ce)
		(sel_ff == ccs_pkg::SEL_FULL && post_ff == 2'h0) ##1 $stable(sel_ff)
		|-> o_mem_cs == $past(i_bus.cs))
		else $error("chip select shaped at full speed");
	rd_two_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n || !i_ce)
		($rose(o_mem_cs) && $past(fast_rd_mode) && $past(post_ff) == 2'h0
		&& $past(sel_ff) != ccs_pkg::SEL_D2) |-> o_mem_cs[*2] ##1 !o_mem_cs)
		else $error("short read select not two cycles");
	wr_four_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n || !i_ce)
		($rose(o_mem_cs) && $past(fast_wr_mode)) |-> o_mem_cs[*4])
		else $error("short write select too short");
	sel_edge_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
		$changed(sel_ff) |-> $past(per_end))
		else $error("clock select changed mid period");

	slow_rd_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
		slow_mode && sh_rd && i_bus.rd && o_mem_cs);
	fast_wr_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
		fast_wr_mode && $rose(o_mem_cs));
	timed_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
		tcnt_ff == 5'h01);
	wdt_c: cover property (@(posedge i_mclk) disable iff (!i_rst_n)
		rst_stat_ff == ccs_pkg::RST_WDT);
endmodule // ccs_top
`default_nettype wire

// [test/ccs_mem_model.sv]
// Memory-side bus cycle generator and shaped select counter
`timescale 1ns/1ns
`default_nettype none
module ccs_mem_model (
	input  wire logic         i_mclk,
	input  wire logic         i_cpu_tick,
	input  wire logic         i_mem_cs,
	input  wire logic         i_go,
	input  wire logic         i_write,
	input  wire logic [2:0]   i_periods,
	output ccs_pkg::ccs_bus_s o_bus,
	output logic              o_done,
	output logic [7:0]        o_len
);
	logic [7:0] cnt_ff;
	always @(posedge i_mclk) cnt_ff <= i_go ? 8'h00 : cnt_ff + {7'h00, i_mem_cs};
	initial begin
		o_bus = '0;
		o_done = 1'b0;
		o_len = 8'h00;
		forever begin
			@(posedge i_mclk);
			o_done <= 1'b0;
			// Idle: deselected, type lines keep changing
			if (!i_go)
				o_bus <= '{cs: 1'b0, rd: ~o_bus.rd, wr: o_bus.rd,
					final_st: 1'b0};
			else begin
				while (!i_cpu_tick) @(posedge i_mclk);
				// Periods aligned to processor ticks
				for (int k = 1; k <= int'(i_periods); k++) begin
					o_bus <= '{cs: 1'b1, rd: !i_write, wr: i_write,
						final_st: k == int'(i_periods)};
					do @(posedge i_mclk); while (!i_cpu_tick);
				end
				o_bus <= '{cs: 1'b0, rd: i_write, wr: !i_write, final_st: 1'b0};
				repeat (70) @(posedge i_mclk);
				o_len <= cnt_ff;
				o_done <= 1'b1;
			end
		end
	end
endmodule // ccs_mem_model
`default_nettype wire

// [test/ccs_top_bench.sv]
// Self-checking bench for the clock select and short select block
`timescale 1ns/1ns
`default_nettype none
module ccs_top_bench;
	typedef struct {string nm; logic [7:0] v;} ccs_note_s;
	localparam logic [31:0] CLK_TAB [9] = '{32'h00000808, 32'h00010801,
		32'h00020101, 32'h00030202, 32'h00060404, 32'h00070606,
		32'h00042020, 32'h04044040, 32'h00052020};
	localparam logic [31:0] CS_TAB [8] = '{32'h10030002, 32'h080b0004,
		32'h10320002, 32'h18230003, 32'h00020010, 32'h10420020,
		32'h084a0040, 32'h8042000e};
	logic        mclk, rst_n, wstb, rstb, slow, wdt, ack, go, wmode, rd_d;
	logic        cpu_tick, per_tick, osc_run, pend, mem_cs, irq, done, ptick;
	logic [1:0]  addr, prio, oprio;
	logic [2:0]  nper;
	logic [7:0]  wdata, rdata, len, n;
	logic [31:0] e;
	ccs_pkg::ccs_bus_s bus;
	ccs_note_s   q[$];
	ccs_note_s   note;
	int          checked, miscompares, cyc, seed;
	ccs_top uut (.i_mclk(mclk), .i_rst_n(rst_n), .i_ce(1'b1), .i_addr(addr),
		.i_wdata(wdata), .i_wr(wstb), .i_rd(rstb), .o_rdata(rdata),
		.i_slow_clk(slow), .i_wdt_timeout(wdt), .i_periodic_tick(ptick),
		.i_periodic_ack(ack), .i_bus(bus), .o_cpu_tick(cpu_tick),
		.o_per_tick(per_tick), .o_osc_run(osc_run), .o_periodic_pend(pend),
		.o_periodic_prio(oprio), .o_mem_cs(mem_cs), .o_irq(irq));
	ccs_mem_model mem (.i_mclk(mclk), .i_cpu_tick(cpu_tick), .i_mem_cs(mem_cs),
		.i_go(go), .i_write(wmode), .i_periods(nper), .o_bus(bus),
		.o_done(done), .o_len(len));
	task automatic stop_test();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input string nm, input logic [7:0] s, input logic [7:0] x);
		checked++;
		if (s !== x) begin
			miscompares++;
			$display("[ERR] %s exp %h seen %h", nm, x, s);
		end
	endtask
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wstb <= 1'b1;
		@(posedge mclk);
		wstb <= 1'b0;
	endtask
	task automatic reg_rd(input logic [1:0] a, input logic [7:0] x);
		q.push_back('{"rdata", x});
		@(posedge mclk);
		addr <= a;
		rstb <= 1'b1;
		@(posedge mclk);
		rstb <= 1'b0;
	endtask
	task automatic span(input logic c, output logic [7:0] m);
		m = 8'h00;
		do @(negedge mclk); while (!(c ? cpu_tick : per_tick));
		do begin
			@(negedge mclk);
			m++;
		end while (!(c ? cpu_tick : per_tick));
	endtask
	task automatic pulse_chk(input string nm, input logic x);
		@(negedge mclk);
		check(nm, {7'h00, (nm == "irq") ? irq : pend}, {7'h00, x});
	endtask
	task automatic cs_run(input logic [31:0] t);
		reg_wr(ccs_pkg::ADDR_PSC, t[31:24]);
		reg_rd(ccs_pkg::ADDR_PSC, t[31:24]);
		reg_wr(ccs_pkg::ADDR_GCS, {3'h0, t[22:20], 2'h0});
		span(1'b1, n);
		span(1'b1, n);
		q.push_back('{"mem_cs", t[7:0]});
		@(posedge mclk);
		wmode <= t[19];
		nper <= t[18:16];
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		do @(negedge mclk); while (!done);
	endtask
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		rd_d <= rstb;
		if (cyc % 16 == 15)
			slow <= ~slow;
		if (cyc == 60000) begin
			miscompares++;
			stop_test();
		end
	end
	always @(negedge mclk) begin
		if (rd_d) begin
			note = q.pop_front();
			check(note.nm, rdata, note.v);
		end
		if (done) begin
			note = q.pop_front();
			check(note.nm, len, note.v);
		end
	end
	initial begin
		{rst_n, wstb, rstb, wdt, ack, go, wmode, slow, rd_d, ptick} = '0;
		addr = 2'h0;
		wdata = 8'h00;
		nper = 3'h1;
		seed = 2644;
		cyc = 0;
		checked = 0;
		miscompares = 0;
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		reg_rd(ccs_pkg::ADDR_GCS, 8'hc0);
		reg_rd(ccs_pkg::ADDR_GCS, 8'h00);
		@(posedge mclk);
		wdt <= 1'b1;
		@(posedge mclk);
		wdt <= 1'b0;
		reg_rd(ccs_pkg::ADDR_GCS, 8'h40);
		reg_wr(ccs_pkg::ADDR_IMSK, 8'h01);
		pulse_chk("irq", 1'b1);
		reg_wr(ccs_pkg::ADDR_IMSK, 8'h00);
		pulse_chk("irq", 1'b0);
		reg_wr(ccs_pkg::ADDR_IMSK, 8'h01);
		reg_wr(ccs_pkg::ADDR_IST, 8'h01);
		pulse_chk("irq", 1'b0);
		reg_wr(ccs_pkg::ADDR_GCS, 8'h20);
		pulse_chk("pend", 1'b0);
		prio = 2'($random(seed));
		if (prio == 2'h0)
			prio = 2'h2;
		reg_wr(ccs_pkg::ADDR_GCS, {6'h08, prio});
		pulse_chk("pend", 1'b1);
		check("prio", {6'h00, oprio}, {6'h00, prio});
		reg_rd(ccs_pkg::ADDR_GCS, {6'h00, prio});
		@(posedge mclk);
		ack <= 1'b1;
		@(posedge mclk);
		ack <= 1'b0;
		pulse_chk("pend", 1'b0);
		@(posedge mclk);
		ptick <= 1'b1;
		@(posedge mclk);
		ptick <= 1'b0;
		pulse_chk("pend", 1'b1);
		for (int i = 0; i < 9; i++) begin
			e = CLK_TAB[i];
			reg_wr(ccs_pkg::ADDR_PSC, e[31:24]);
			reg_wr(ccs_pkg::ADDR_GCS, {3'h0, e[18:16], 2'h0});
			span(1'b1, n);
			span(1'b1, n);
			check("cpu_period", n, e[15:8]);
			span(1'b0, n);
			check("per_period", n, e[7:0]);
			check("osc_run", {7'h00, osc_run}, {7'h00, e[18:16] != 3'h5});
		end
		for (int i = 0; i < 8; i++)
			cs_run(CS_TAB[i]);
		stop_test();
	end
endmodule // ccs_top_bench
`default_nettype wire
